// file: verilog/sdc_pkg.sv
// How it works
// - Panel start key starts, stop key stops, when the panel is the command source.
// - Operating mode shows present speed on three display digits.
// - Error LED lights on any error or overload; ready, zero and reached LEDs beside it.
// - Overload opens relay 2; any general error opens ready relay 3.
// - Set-point comes from exactly one source: knob, analogue input or serial link.
// - Analogue scaling defaults to ten thousand rpm per volt.
// - Stop key alone held four seconds while stopped enters direction setup.
// - In direction setup each key press toggles right and left, shown on display.
// - Chosen direction is written to non-volatile storage and restored after reset.
// - Setup modes return to operating mode after an idle interval without presses.
// - Start and stop held together four seconds enter characteristic selection.
// - In selection, start steps to next higher slot, stop to next lower.
// - Sixteen characteristic slots, each used or empty, with one selection index.
// - An empty selected slot shows E and its number until a used one is chosen.
// - A used selected slot shows its number as two digits.
// - Start is refused without a preset set-point, except for analogue start.
// - Remote start/stop comes from digital input 1 unless another is configured.
// - Each digital input has its own low-true or high-true polarity.
// - Analogue start needs the analogue start assignment and a valid start/stop input.
// - Under analogue start zero volts stops; any higher voltage runs at scaled speed.
// - Only the selected command source may stop; safety stops override it.
// - A direction change while turning waits until the spindle is stopped and at standstill, not for the next start.
// - With error reporting on, active error codes cycle on the display.
package sdc_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_HZ = 20_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int HOLD_MS = 4000;
   localparam int IDLE_MS = 8000;
   localparam int DEB_MS = 10;
   localparam int ERR_SHOW_MS = 1000;
   localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
   localparam int IDLE_CYC = IDLE_MS * CYC_PER_MS;
   localparam int DEB_CYC = DEB_MS * CYC_PER_MS;
   localparam int ERR_SHOW_CYC = ERR_SHOW_MS * CYC_PER_MS;
   localparam int CNT_W = 28;

   // ************************************************************
   // Sizes, scaling and reset values
   // ************************************************************
   localparam int N_DIN = 4;
   localparam int N_SLOT = 16;
   localparam logic [15:0] RPM_PER_V_DEF = 16'h2710;
   localparam logic [31:0] MV_PER_V = 32'h0000_03E8;
   localparam logic [15:0] RPM_PER_DIGIT = 16'h0064;
   localparam logic [9:0] DISP_MAX = 10'h3E7;
   localparam logic [5:0] ERR_CODE_BASE = 6'h1E;
   localparam logic DIR_RESET = 1'b1;
   localparam logic [3:0] SLOT_RESET = 4'h0;
   localparam logic [1:0] SS_INPUT_DEF = 2'h0;

   // Display digit codes: 0 to 9 are numerals.
   localparam logic [3:0] DG_R = 4'hA;
   localparam logic [3:0] DG_L = 4'hB;
   localparam logic [3:0] DG_E = 4'hE;
   localparam logic [3:0] DG_BLANK = 4'hF;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_RUN = 2'b00,
      MODE_DIR = 2'b01,
      MODE_CHAR = 2'b10
   } sdc_mode_type;

   typedef enum logic [1:0] {
      SRC_PANEL = 2'b00,
      SRC_DIGITAL = 2'b01,
      SRC_ANALOG = 2'b10,
      SRC_SERIAL = 2'b11
   } sdc_src_type;

   typedef struct packed {
      logic [N_DIN-1:0] din_low_true;
      logic [1:0] ss_input;
      logic [1:0] dir_input;
      logic dir_from_input;
      sdc_src_type cmd_source;
      sdc_src_type sp_source;
      logic analog_start;
      logic err_report;
      logic [15:0] rpm_per_volt;
   } sdc_cfg_type;

   typedef struct packed {
      logic [3:0] d2;
      logic [3:0] d1;
      logic [3:0] d0;
   } sdc_disp_type;

   typedef struct packed {
      logic led_ready;
      logic led_zero;
      logic led_reached;
      logic led_error;
      logic relay1;
      logic relay2;
      logic relay3;
   } sdc_stat_type;

endpackage : sdc_pkg

// file: verilog/sdc_debounce.sv
`timescale 1ns/1ps
module sdc_debounce
   import sdc_pkg::*;
#(
   parameter int CYC = DEB_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic pin,
   output logic level,
   output logic rise
);

   logic [1:0] sync_q, sync_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic level_q, level_d;
   logic rise_q, rise_d;

   // ************************************************************
   // Synchroniser and stability filter
   // ************************************************************
   always_comb begin
      sync_d = {sync_q[0], pin};
      cnt_d = '0;
      level_d = level_q;
      rise_d = 1'b0;
      if (sync_q[1] != level_q) begin
         if (cnt_q == CNT_W'(CYC - 1)) begin
            level_d = sync_q[1];
            rise_d = sync_q[1];
         end else begin
            cnt_d = cnt_q + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync_q <= 2'h0;
         cnt_q <= '0;
         level_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         sync_q <= sync_d;
         cnt_q <= cnt_d;
         level_q <= level_d;
         rise_q <= rise_d;
      end
   end

   assign level = level_q;
   assign rise = rise_q;

   chk_deb_settled: assert property (
      @(posedge clk_sys) disable iff (rst)
      $rose(level_q) |-> $past(sync_q[1]) && $past(cnt_q) == CNT_W'(CYC - 1))
      else $error("Debounced level rose without a settled input.");

endmodule : sdc_debounce

// file: verilog/sdc_panel.sv
`timescale 1ns/1ps
module sdc_panel
   import sdc_pkg::*;
#(
   parameter int DEB_CYCLES = DEB_CYC,
   parameter int HOLD_CYCLES = HOLD_CYC,
   parameter int IDLE_CYCLES = IDLE_CYC,
   parameter int ERR_CYCLES = ERR_SHOW_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic key_start,
   input wire logic key_stop,
   input wire logic [N_DIN-1:0] din,
   input wire sdc_cfg_type cfg,
   input wire logic [15:0] knob_rpm,
   input wire logic [13:0] analog_mv,
   input wire logic [15:0] serial_rpm,
   input wire logic serial_start,
   input wire logic serial_stop,
   input wire logic [15:0] speed_rpm,
   input wire logic overload,
   input wire logic [15:0] error_flags,
   input wire logic safety_stop,
   input wire logic nv_dir,
   input wire logic [N_SLOT-1:0] slot_used,
   output logic spindle_run,
   output logic spindle_cw,
   output logic [15:0] setpoint_rpm,
   output logic [3:0] char_slot,
   output sdc_mode_type panel_mode,
   output sdc_disp_type disp,
   output sdc_stat_type status,
   output logic nv_dir_wr,
   output logic nv_dir_wdata
);

   // ************************************************************
   // Input conditioning
   // ************************************************************
   logic [N_DIN+1:0] raw_w, lvl_w, rise_w;
   logic start_p, stop_p, start_l, stop_l, any_p;
   logic [N_DIN-1:0] din_act;
   logic ss_act, dir_pref, preset, stop_all, err_any;
   logic [31:0] ana_prod, ana_div;
   logic [15:0] ana_rpm;

   assign raw_w = {din, key_stop, key_start};

   genvar gi;
   generate
      for (gi = 0; gi < N_DIN + 2; gi++) begin : g_deb
         sdc_debounce #(.CYC(DEB_CYCLES)) u_deb (
            .clk_sys(clk_sys),
            .rst(rst),
            .pin(raw_w[gi]),
            .level(lvl_w[gi]),
            .rise(rise_w[gi])
         );
      end
   endgenerate

   assign start_p = rise_w[0];
   assign stop_p = rise_w[1];
   assign start_l = lvl_w[0];
   assign stop_l = lvl_w[1];
   assign any_p = start_p | stop_p;
   // A low-true input reads active when its pin is low, so a cut cable reads as an active input.
   assign din_act = lvl_w[N_DIN+1:2] ^ cfg.din_low_true;
   assign ss_act = din_act[cfg.ss_input];
   assign err_any = |error_flags;
   assign stop_all = safety_stop | err_any;

   // Scaled analogue set-point, saturated at the top of the speed range.
   assign ana_prod = 32'(analog_mv) * 32'(cfg.rpm_per_volt);
   assign ana_div = ana_prod / MV_PER_V;
   assign ana_rpm = (|ana_div[31:16]) ? 16'hFFFF : ana_div[15:0];

   // ************************************************************
   // Control state
   // ************************************************************
   sdc_mode_type mode_q, mode_d;
   logic [CNT_W-1:0] hold_q, hold_d, idle_q, idle_d;
   logic pair_q, pair_d;
   logic [3:0] slot_q, slot_d;
   logic dir_q, dir_d, dir_run_q, dir_run_d;
   logic run_q, run_d, restore_q, restore_d, nv_wr_q, nv_wr_d;
   logic [15:0] setpoint_q, setpoint_d;

   assign preset = setpoint_q != 16'h0000;
   assign dir_pref = cfg.dir_from_input ? din_act[cfg.dir_input] : dir_q;

   always_comb begin
      mode_d = mode_q;
      hold_d = '0;
      idle_d = '0;
      pair_d = start_l;
      slot_d = slot_q;
      dir_d = dir_q;
      run_d = run_q;
      restore_d = 1'b1;
      nv_wr_d = 1'b0;
      setpoint_d = knob_rpm;
      case (mode_q)
         MODE_RUN: begin
            // The hold restarts whenever the key pair changes, so each gesture is timed alone.
            if (stop_l && (start_l || !run_q) && (pair_q == start_l)) begin
               hold_d = hold_q + CNT_W'(1);
            end
            if (hold_q == CNT_W'(HOLD_CYCLES - 1)) begin
               hold_d = '0;
               mode_d = start_l ? MODE_CHAR : MODE_DIR;
            end
         end
         MODE_DIR: begin
            if (any_p) begin
               dir_d = ~dir_q;
               nv_wr_d = 1'b1;
            end
         end
         MODE_CHAR: begin
            if (start_p && !stop_p) begin
               slot_d = slot_q + 4'h1;
            end else if (stop_p && !start_p) begin
               slot_d = slot_q - 4'h1;
            end
         end
         default: begin
            mode_d = MODE_RUN;
         end
      endcase
      if (mode_q != MODE_RUN && !any_p) begin
         idle_d = idle_q + CNT_W'(1);
         if (idle_q == CNT_W'(IDLE_CYCLES - 1)) begin
            idle_d = '0;
            mode_d = MODE_RUN;
         end
      end
      if (!restore_q) begin
         dir_d = nv_dir;
      end
      case (cfg.sp_source)
         SRC_ANALOG: setpoint_d = ana_rpm;
         SRC_SERIAL: setpoint_d = serial_rpm;
         default: setpoint_d = knob_rpm;
      endcase
      // Each source only acts while it is the selected one; others cannot stop the spindle.
      case (cfg.cmd_source)
         SRC_PANEL: begin
            if (mode_q == MODE_RUN && stop_p) begin
               run_d = 1'b0;
            end else if (mode_q == MODE_RUN && start_p && preset) begin
               run_d = 1'b1;
            end
         end
         SRC_DIGITAL: run_d = ss_act && (run_q || preset);
         SRC_ANALOG: run_d = cfg.analog_start && ss_act && (analog_mv != 14'h0000);
         SRC_SERIAL: begin
            if (serial_stop) begin
               run_d = 1'b0;
            end else if (serial_start && preset) begin
               run_d = 1'b1;
            end
         end
         default: run_d = 1'b0;
      endcase
      if (stop_all) begin
         run_d = 1'b0;
      end
      // A new direction is only taken once the spindle is stopped and still.
      dir_run_d = (!run_q && speed_rpm == 16'h0000) ? dir_pref : dir_run_q;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_q <= MODE_RUN;
         hold_q <= '0;
         idle_q <= '0;
         pair_q <= 1'b0;
         slot_q <= SLOT_RESET;
         dir_q <= DIR_RESET;
         dir_run_q <= DIR_RESET;
         run_q <= 1'b0;
         restore_q <= 1'b0;
         nv_wr_q <= 1'b0;
         setpoint_q <= 16'h0000;
      end else begin
         mode_q <= mode_d;
         hold_q <= hold_d;
         idle_q <= idle_d;
         pair_q <= pair_d;
         slot_q <= slot_d;
         dir_q <= dir_d;
         dir_run_q <= dir_run_d;
         run_q <= run_d;
         restore_q <= restore_d;
         nv_wr_q <= nv_wr_d;
         setpoint_q <= setpoint_d;
      end
   end

   // ************************************************************
   // Display, LEDs and relays
   // ************************************************************
   sdc_disp_type disp_q, disp_d;
   sdc_stat_type stat_q, stat_d;
   logic [3:0] err_idx_q, err_idx_d;
   logic [CNT_W-1:0] err_tick_q, err_tick_d;
   logic [15:0] spd_div;
   logic [9:0] spd_val;
   logic [4:0] slot_num;
   logic [5:0] err_code;

   assign spd_div = speed_rpm / RPM_PER_DIGIT;
   assign spd_val = (spd_div > 16'(DISP_MAX)) ? DISP_MAX : spd_div[9:0];
   assign slot_num = {1'b0, slot_q} + 5'h01;
   assign err_code = ERR_CODE_BASE + {2'h0, err_idx_q};

   always_comb begin
      err_idx_d = err_idx_q;
      err_tick_d = '0;
      // Empty positions are skipped one per cycle, so a set flag is reached within sixteen.
      if (!error_flags[err_idx_q]) begin
         err_idx_d = err_idx_q + 4'h1;
      end else if (err_tick_q == CNT_W'(ERR_CYCLES - 1)) begin
         err_idx_d = err_idx_q + 4'h1;
      end else begin
         err_tick_d = err_tick_q + CNT_W'(1);
      end
      case (mode_q)
         MODE_DIR: disp_d = '{DG_BLANK, DG_BLANK, dir_q ? DG_R : DG_L};
         MODE_CHAR: begin
            disp_d.d2 = slot_used[slot_q] ? DG_BLANK : DG_E;
            disp_d.d1 = (slot_num >= 5'h0A) ? 4'h1 : 4'h0;
            disp_d.d0 = 4'(slot_num % 5'h0A);
         end
         default: begin
            if (cfg.err_report && error_flags[err_idx_q]) begin
               disp_d = '{DG_E, 4'(err_code / 6'h0A), 4'(err_code % 6'h0A)};
            end else begin
               disp_d.d2 = 4'(spd_val / 10'h064);
               disp_d.d1 = 4'((spd_val / 10'h00A) % 10'h00A);
               disp_d.d0 = 4'(spd_val % 10'h00A);
            end
         end
      endcase
      stat_d.led_ready = !err_any;
      stat_d.led_zero = speed_rpm == 16'h0000;
      stat_d.led_reached = run_q && preset && (speed_rpm >= setpoint_q);
      stat_d.led_error = err_any || overload;
      stat_d.relay1 = run_q && preset && (speed_rpm >= setpoint_q);
      stat_d.relay2 = !overload;
      stat_d.relay3 = !err_any;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         disp_q <= '{DG_BLANK, DG_BLANK, DG_BLANK};
         stat_q <= '0;
         err_idx_q <= 4'h0;
         err_tick_q <= '0;
      end else begin
         disp_q <= disp_d;
         stat_q <= stat_d;
         err_idx_q <= err_idx_d;
         err_tick_q <= err_tick_d;
      end
   end

   assign spindle_run = run_q;
   assign spindle_cw = dir_run_q;
   assign setpoint_rpm = setpoint_q;
   assign char_slot = slot_q;
   assign panel_mode = mode_q;
   assign disp = disp_q;
   assign status = stat_q;
   assign nv_dir_wr = nv_wr_q;
   assign nv_dir_wdata = dir_q;

   // ************************************************************
   // Checks
   // ************************************************************
   chk_panel_start: assert property (
      @(posedge clk_sys) disable iff (rst)
      cfg.cmd_source == SRC_PANEL && mode_q == MODE_RUN && start_p && !stop_p && preset && !stop_all
      |=> run_q)
      else $error("Panel start key did not start the spindle.");

   chk_start_preset: assert property (
      @(posedge clk_sys) disable iff (rst)
      $rose(run_q) && $past(cfg.cmd_source) != SRC_ANALOG |-> $past(preset))
      else $error("Spindle started without a preset set-point.");

   chk_stop_owner: assert property (
      @(posedge clk_sys) disable iff (rst)
      run_q && cfg.cmd_source == SRC_SERIAL && !serial_stop && !stop_all |=> run_q)
      else $error("Spindle stopped by a source that does not own it.");

   chk_analog_zero: assert property (
      @(posedge clk_sys) disable iff (rst)
      cfg.cmd_source == SRC_ANALOG && analog_mv == 14'h0000 |=> !run_q)
      else $error("Analogue start at zero volts did not stop.");

   chk_dir_hold: assert property (
      @(posedge clk_sys) disable iff (rst)
      run_q ##1 run_q |-> $stable(dir_run_q))
      else $error("Direction changed while the spindle was running.");

   chk_fault_relays: assert property (
      @(posedge clk_sys) disable iff (rst)
      (err_any || overload) |=> status.led_error && (status.relay3 == !$past(err_any))
      && (status.relay2 == !$past(overload)))
      else $error("Relay or error LED did not follow the fault state.");

   chk_dir_entry: assert property (
      @(posedge clk_sys) disable iff (rst)
      mode_q == MODE_RUN && hold_q == CNT_W'(HOLD_CYCLES - 1) && !start_l |=> mode_q == MODE_DIR)
      else $error("Stop key hold did not enter direction setup.");

   chk_idle_exit: assert property (
      @(posedge clk_sys) disable iff (rst)
      mode_q != MODE_RUN && !any_p && idle_q == CNT_W'(IDLE_CYCLES - 1) |=> mode_q == MODE_RUN)
      else $error("Setup mode did not time out to operating mode.");

   chk_slot_step: assert property (
      @(posedge clk_sys) disable iff (rst)
      mode_q == MODE_CHAR && start_p && !stop_p |=> slot_q == $past(slot_q) + 4'h1)
      else $error("Start key did not step to the next slot.");

   chk_empty_slot: assert property (
      @(posedge clk_sys) disable iff (rst)
      mode_q == MODE_CHAR && !slot_used[slot_q] |=> disp.d2 == DG_E)
      else $error("Empty slot not shown as an error.");

endmodule : sdc_panel

// file: testbench/sdc_partner.sv
`timescale 1ns/1ps
module sdc_partner (
   input wire logic clk_sys,
   input wire logic want_start,
   input wire logic want_stop,
   input wire logic [3:0] want_din,
   input wire logic [3:0] low_true,
   output logic key_start,
   output logic key_stop,
   output logic [3:0] din
);
   // ************************************************************
   // Operator keys with contact bounce, PLC outputs
   // ************************************************************
   logic [1:0] last_q = 2'h0;
   logic [1:0] chg_q = 2'h0;
   logic [1:0] bounce_q = 2'h0;
   // A real key chatters for a few cycles, shorter than the debounce time.
   always @(posedge clk_sys) begin
      last_q <= {want_start, want_stop};
      if ({want_start, want_stop} != last_q) begin
         chg_q <= {want_start, want_stop} ^ last_q;
         bounce_q <= 2'h3;
      end else if (bounce_q != 2'h0) begin
         bounce_q <= bounce_q - 2'h1;
      end
      {key_start, key_stop} <= {want_start, want_stop} ^ (bounce_q[0] ? chg_q : 2'h0);
      din <= want_din ^ low_true;
   end
endmodule : sdc_partner

// file: testbench/sdc_panel_tb.sv
`timescale 1ns/1ps
module sdc_panel_tb;
   import sdc_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic want_start, want_stop, key_start, key_stop;
   logic [3:0] want_din, low_true, din, char_slot;
   sdc_cfg_type cfg;
   logic [15:0] knob_rpm, serial_rpm, speed_rpm, error_flags, slot_used, setpoint_rpm;
   logic [13:0] analog_mv;
   logic serial_start, serial_stop, overload, safety_stop, nv_dir;
   logic spindle_run, spindle_cw, nv_dir_wr, nv_dir_wdata;
   sdc_mode_type panel_mode;
   sdc_disp_type disp;
   sdc_stat_type status;
   int fail_count = 0;
   int tests_run = 0;
   int seed = 1;
   int nv_wr_count = 0;
   logic [2:0] note_q[$];
   logic [2:0] prev_obs = 3'h0;

   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   sdc_partner partner (.clk_sys(clk_sys), .want_start(want_start), .want_stop(want_stop), .want_din(want_din),
      .low_true(low_true), .key_start(key_start), .key_stop(key_stop), .din(din));

   // Short counts keep the run brief; the waits below are fixed cycle counts or bounded polls, chosen to cover them.
   sdc_panel #(.DEB_CYCLES(4), .HOLD_CYCLES(20), .IDLE_CYCLES(40), .ERR_CYCLES(8)) dut (.clk_sys(clk_sys),
      .rst(rst), .key_start(key_start), .key_stop(key_stop), .din(din), .cfg(cfg), .knob_rpm(knob_rpm),
      .analog_mv(analog_mv), .serial_rpm(serial_rpm), .serial_start(serial_start), .serial_stop(serial_stop),
      .speed_rpm(speed_rpm), .overload(overload), .error_flags(error_flags), .safety_stop(safety_stop),
      .nv_dir(nv_dir), .slot_used(slot_used), .spindle_run(spindle_run), .spindle_cw(spindle_cw),
      .setpoint_rpm(setpoint_rpm), .char_slot(char_slot), .panel_mode(panel_mode), .disp(disp),
      .status(status), .nv_dir_wr(nv_dir_wr), .nv_dir_wdata(nv_dir_wdata));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt

   task automatic press(input logic s, input logic p, input int n);
      want_start <= s;
      want_stop <= p;
      wt(n);
      want_start <= 1'b0;
      want_stop <= 1'b0;
      wt(16);
   endtask : press

   task automatic pulse(input logic s, input logic p);
      serial_start <= s;
      serial_stop <= p;
      wt(1);
      serial_start <= 1'b0;
      serial_stop <= 1'b0;
      wt(3);
   endtask : pulse

   // ************************************************************
   // Monitor: each change of run or mode consumes the oldest note
   // ************************************************************
   always @(negedge clk_sys) begin
      if (!rst && {spindle_run, panel_mode} !== prev_obs) begin
         if (note_q.size() == 0) begin
            check({13'h0, spindle_run, panel_mode}, 16'hFFFF);
         end else begin
            check({13'h0, spindle_run, panel_mode}, {13'h0, note_q.pop_front()});
         end
      end
      prev_obs = {spindle_run, panel_mode};
      if (nv_dir_wr === 1'b1) nv_wr_count++;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      results();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      want_start = 1'b0;
      want_stop = 1'b0;
      want_din = 4'h0;
      low_true = 4'h0;
      cfg = '{din_low_true: 4'h0, ss_input: SS_INPUT_DEF, dir_input: 2'h0, dir_from_input: 1'b0,
         cmd_source: SRC_PANEL, sp_source: SRC_PANEL, analog_start: 1'b0, err_report: 1'b0,
         rpm_per_volt: RPM_PER_V_DEF};
      {knob_rpm, serial_rpm, speed_rpm, error_flags, analog_mv} = 78'h0;
      {serial_start, serial_stop, overload, safety_stop} = 4'h0;
      // Stored direction differs from the reset value, so the restore is visible.
      nv_dir = 1'b0;
      slot_used = 16'h8001;
      wt(12);
      check({9'h0, status}, 16'h0000);
      rst <= 1'b0;
      wt(4);
      press(1'b1, 1'b0, 16);
      check({15'h0, spindle_run}, 16'h0000);
      knob_rpm <= (16'($random(seed)) & 16'h3FFF) | 16'h0010;
      wt(3);
      check(setpoint_rpm, knob_rpm);
      note_q.push_back({1'b1, MODE_RUN});
      press(1'b1, 1'b0, 16);
      speed_rpm <= 16'h3039;
      wt(4);
      check({4'h0, disp}, 16'h0123);
      check({9'h0, status}, {9'h0, 2'b10, 16'h3039 >= knob_rpm, 1'b0, 16'h3039 >= knob_rpm, 2'b11});
      pulse(1'b0, 1'b1);
      check({15'h0, spindle_run}, 16'h0001);
      overload <= 1'b1;
      wt(4);
      check({13'h0, spindle_run, status.relay2, status.led_error}, 16'h0005);
      overload <= 1'b0;
      cfg.err_report <= 1'b1;
      error_flags <= 16'h0004;
      note_q.push_back({1'b0, MODE_RUN});
      wt(40);
      // The code is shown only while the cycling index rests on its flag.
      for (int i = 0; i < 30 && disp.d2 !== DG_E; i++) wt(1);
      check({3'h0, status.relay3, disp}, {3'h0, 1'b0, DG_E, 8'h32});
      error_flags <= 16'h0000;
      cfg.err_report <= 1'b0;
      wt(4);
      note_q.push_back({1'b1, MODE_RUN});
      press(1'b1, 1'b0, 16);
      note_q.push_back({1'b0, MODE_RUN});
      safety_stop <= 1'b1;
      wt(4);
      safety_stop <= 1'b0;
      speed_rpm <= 16'h0000;
      wt(4);
      $display("test panel done");
      cfg.dir_from_input <= 1'b1;
      cfg.dir_input <= 2'h1;
      want_din <= 4'h2;
      wt(16);
      note_q.push_back({1'b1, MODE_RUN});
      press(1'b1, 1'b0, 16);
      speed_rpm <= 16'h01F4;
      want_din <= 4'h0;
      wt(16);
      check({15'h0, spindle_cw}, 16'h0001);
      note_q.push_back({1'b0, MODE_RUN});
      press(1'b0, 1'b1, 16);
      check({15'h0, spindle_cw}, 16'h0001);
      speed_rpm <= 16'h0000;
      wt(3);
      check({15'h0, spindle_cw}, 16'h0000);
      cfg.dir_from_input <= 1'b0;
      wt(4);
      $display("test direction input done");
      note_q.push_back({1'b0, MODE_DIR});
      want_stop <= 1'b1;
      wt(30);
      press(1'b1, 1'b0, 16);
      check({4'h0, disp}, {4'h0, DG_BLANK, DG_BLANK, DG_R});
      check({nv_wr_count[14:0], nv_dir_wdata}, 16'h0003);
      note_q.push_back({1'b0, MODE_RUN});
      wt(60);
      check({15'h0, spindle_cw}, 16'h0001);
      note_q.push_back({1'b0, MODE_CHAR});
      press(1'b1, 1'b1, 30);
      press(1'b1, 1'b0, 16);
      check({char_slot, disp}, {4'h1, DG_E, 8'h02});
      press(1'b0, 1'b1, 16);
      press(1'b0, 1'b1, 16);
      check({char_slot, disp}, {4'hF, DG_BLANK, 8'h16});
      note_q.push_back({1'b0, MODE_RUN});
      wt(60);
      $display("test setup modes done");
      cfg.cmd_source <= SRC_SERIAL;
      cfg.sp_source <= SRC_SERIAL;
      serial_rpm <= (16'($random(seed)) & 16'h7FFF) | 16'h0001;
      wt(3);
      check(setpoint_rpm, serial_rpm);
      note_q.push_back({1'b1, MODE_RUN});
      pulse(1'b1, 1'b0);
      press(1'b0, 1'b1, 16);
      check({15'h0, spindle_run}, 16'h0001);
      note_q.push_back({1'b0, MODE_RUN});
      pulse(1'b1, 1'b1);
      $display("test serial done");
      cfg.cmd_source <= SRC_ANALOG;
      cfg.sp_source <= SRC_ANALOG;
      cfg.analog_start <= 1'b1;
      want_din <= 4'h1;
      analog_mv <= 14'h0FA0;
      note_q.push_back({1'b1, MODE_RUN});
      wt(16);
      check(setpoint_rpm, 16'h9C40);
      note_q.push_back({1'b0, MODE_RUN});
      analog_mv <= 14'h0000;
      want_din <= 4'h0;
      low_true <= 4'h4;
      wt(16);
      $display("test analogue done");
      cfg.cmd_source <= SRC_DIGITAL;
      cfg.sp_source <= SRC_PANEL;
      cfg.analog_start <= 1'b0;
      cfg.ss_input <= 2'h2;
      cfg.din_low_true <= 4'h4;
      wt(4);
      note_q.push_back({1'b1, MODE_RUN});
      want_din <= 4'h4;
      wt(16);
      note_q.push_back({1'b0, MODE_RUN});
      want_din <= 4'h0;
      wt(16);
      check({15'h0, spindle_run}, 16'h0000);
      $display("test digital done");
      for (int i = 0; i < 100 && note_q.size() != 0; i++) wt(1);
      check({10'h0, 6'(note_q.size())}, 16'h0000);
      results();
   end
endmodule : sdc_panel_tb
